// ---- rtl/rmb_regs.sv ----
// AHB-Lite register bank for radio mode and baseband control
// Function
// - Writing sleep request bit puts device asleep; bit clears itself.
// - Nine-bit start-up count: low seven in sleep register, top two in mode.
// - Oscillator start-up counts sleep ticks to the count; count resets zero.
// - Mode reset bit held high keeps radio state machine in reset.
// - Mode bit 1 forces transmit state, bit 0 forces receive state.
// - Decrypt trigger runs decryption on normal FIFO, self-clears when done.
// - Encrypt trigger runs encryption on normal FIFO, self-clears when done.
// - Slot-2 suite field encodes MAC, CCM, CTR or none; resets none.
// - Slot-1 suite field uses same encoding, resets to none.
// - Rate bit one selects 625 kbps, zero selects 250 kbps.
// - Invert bit flips sign of decoded receive symbols.
// - Two-bit channel check mode selects busy criterion, default carrier.
// - Four-bit carrier-sense level resets to 0010.
// - Preamble valid level resets to 1101; 0011 suits high rate.
// - Preamble detect level resets to 4.
// - Carrier level resets to 100; 010 suits high rate.
// - Preamble count level resets to 111.
// - One-shot RSSI starts one measurement; done flag low while measuring.
// - Per-packet RSSI bit enables RSSI storing for every packet.
// - Sleep tick source 10 internal, 01 crystal; sets count unit.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module rmb_regs (
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    // AHB-Lite slave
    input  wire logic               hsel_i,
    input  wire logic [9:0]         haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic [31:0]             hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    // Sleep side
    input  wire logic               sleep_tick_i,
    input  wire logic               wake_i,
    input  wire logic [1:0]         sleep_tick_source_i,
    output logic                    asleep_o,
    output logic                    osc_ready_o,
    // Radio, cipher and measurement side
    output rmb_pkg::rmb_cfg_s       cfg_o,
    output rmb_pkg::rmb_pulse_s     pulse_o,
    output logic                    radio_fsm_hold_o,
    output logic                    cipher_busy_o,
    output logic                    rssi_done_o,
    output logic                    tick_internal_o,
    output logic                    tick_crystal_o
);

    typedef enum logic [1:0] {
        PWR_AWAKE,
        PWR_SLEEP,
        PWR_WARMUP
    } rmb_pwr_e;

    typedef struct packed {
        rmb_pkg::rmb_cfg_s   cfg;
        rmb_pkg::rmb_pulse_s pulse;
        rmb_pwr_e            pwr;
        logic [8:0]          wake_count;
        logic [2:0]          tick_sync;
        logic [2:0]          wake_sync;
        logic                decrypt_pend;
        logic                encrypt_pend;
        logic                wr_pend;
        logic [7:0]          wr_idx;
        logic [31:0]         rdata;
        logic                osc_ready;
    } rmb_state_s;

    rmb_state_s st_r;
    rmb_state_s st_nxt;

    logic        cipher_busy;
    logic        cipher_done;
    logic        rssi_busy;
    logic        addr_phase;
    logic [7:0]  addr_idx;
    logic [7:0]  wd;
    logic [31:0] rd_word;
    logic        tick_rise;

    // ========================================
    // Operation timers
    rmb_op_timer #(
        .CYCLES (rmb_pkg::CIPHER_CYCLES)
    ) u_cipher_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (st_r.pulse.decrypt_go | st_r.pulse.encrypt_go),
        .busy_o    (cipher_busy),
        .done_o    (cipher_done)
    );

    rmb_op_timer #(
        .CYCLES (rmb_pkg::RSSI_CYCLES)
    ) u_rssi_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (st_r.pulse.rssi_go),
        .busy_o    (rssi_busy),
        .done_o    ()
    );

    // ========================================
    // Bus decode
    assign addr_phase = hsel_i & hready_i & htrans_i[1];
    assign addr_idx   = haddr_i[9:2];
    assign wd         = hwdata_i[7:0];
    // Edge of the synchronised tick, never the first stage
    assign tick_rise  = st_r.tick_sync[1] & ~st_r.tick_sync[2];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_idx == rmb_pkg::IDX_SLEEP_WAKE) begin
            // Trigger bit reads zero, it only lives for one cycle
            rd_word[6:0] = st_r.cfg.osc_startup_count[6:0];
        end else if (addr_idx == rmb_pkg::IDX_MODE_CTRL) begin
            rd_word[4:3] = st_r.cfg.osc_startup_count[8:7];
            rd_word[2]   = st_r.cfg.radio_fsm_reset;
            rd_word[1]   = st_r.cfg.force_tx_state;
            rd_word[0]   = st_r.cfg.force_rx_state;
        end else if (addr_idx == rmb_pkg::IDX_SEC_SUITE) begin
            rd_word[7]   = st_r.decrypt_pend;
            rd_word[6]   = st_r.encrypt_pend;
            rd_word[5:3] = st_r.cfg.slot2_suite_sel;
            rd_word[2:0] = st_r.cfg.slot1_suite_sel;
        end else if (addr_idx == rmb_pkg::IDX_RATE_SEL) begin
            rd_word[0]   = st_r.cfg.high_rate;
        end else if (addr_idx == rmb_pkg::IDX_DEC_INVERT) begin
            rd_word[2]   = st_r.cfg.rx_symbol_invert;
        end else if (addr_idx == rmb_pkg::IDX_CHAN_CHECK) begin
            rd_word[7:6] = st_r.cfg.channel_check_mode;
            rd_word[5:2] = st_r.cfg.channel_check_cs_level;
        end else if (addr_idx == rmb_pkg::IDX_PREAMBLE_CFG) begin
            rd_word[7:4] = st_r.cfg.preamble_valid_level;
            rd_word[3:1] = st_r.cfg.preamble_detect_level;
        end else if (addr_idx == rmb_pkg::IDX_CARRIER_CFG) begin
            rd_word[7:5] = st_r.cfg.carrier_level;
            rd_word[4:2] = st_r.cfg.preamble_count_level;
        end else if (addr_idx == rmb_pkg::IDX_RSSI_CTRL) begin
            rd_word[6]   = st_r.cfg.rssi_per_packet;
            rd_word[0]   = ~(rssi_busy | st_r.pulse.rssi_go);
        end
    end

    // ========================================
    // Next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.pulse = '0;
        st_nxt.tick_sync = {st_r.tick_sync[1:0], sleep_tick_i};
        st_nxt.wake_sync = {st_r.wake_sync[1:0], wake_i};

        // Finishing clears the pending trigger bits
        if (cipher_done) begin
            st_nxt.decrypt_pend = 1'b0;
            st_nxt.encrypt_pend = 1'b0;
        end

        // Bus write lands in the data phase
        if (st_r.wr_pend) begin
            if (st_r.wr_idx == rmb_pkg::IDX_SLEEP_WAKE) begin
                st_nxt.cfg.osc_startup_count[6:0] = wd[6:0];
                st_nxt.pulse.sleep_req = wd[rmb_pkg::SLEEP_REQ_BIT];
            end else if (st_r.wr_idx == rmb_pkg::IDX_MODE_CTRL) begin
                st_nxt.cfg.osc_startup_count[8:7] = wd[4:3];
                st_nxt.cfg.radio_fsm_reset = wd[rmb_pkg::MODE_RESET_BIT];
                st_nxt.cfg.force_tx_state  = wd[rmb_pkg::MODE_TX_BIT];
                st_nxt.cfg.force_rx_state  = wd[rmb_pkg::MODE_RX_BIT];
            end else if (st_r.wr_idx == rmb_pkg::IDX_SEC_SUITE) begin
                st_nxt.cfg.slot2_suite_sel = wd[5:3];
                st_nxt.cfg.slot1_suite_sel = wd[2:0];
                // A second trigger while busy is dropped
                if (!cipher_busy && !st_r.decrypt_pend
                        && !st_r.encrypt_pend) begin
                    // Decrypt wins when both are set together
                    if (wd[rmb_pkg::DECRYPT_BIT]) begin
                        st_nxt.decrypt_pend     = 1'b1;
                        st_nxt.pulse.decrypt_go = 1'b1;
                    end else if (wd[rmb_pkg::ENCRYPT_BIT]) begin
                        st_nxt.encrypt_pend     = 1'b1;
                        st_nxt.pulse.encrypt_go = 1'b1;
                    end
                end
            end else if (st_r.wr_idx == rmb_pkg::IDX_RATE_SEL) begin
                st_nxt.cfg.high_rate = wd[rmb_pkg::RATE_BIT];
            end else if (st_r.wr_idx == rmb_pkg::IDX_DEC_INVERT) begin
                st_nxt.cfg.rx_symbol_invert = wd[rmb_pkg::INVERT_BIT];
            end else if (st_r.wr_idx == rmb_pkg::IDX_CHAN_CHECK) begin
                st_nxt.cfg.channel_check_mode     = wd[7:6];
                st_nxt.cfg.channel_check_cs_level = wd[5:2];
            end else if (st_r.wr_idx == rmb_pkg::IDX_PREAMBLE_CFG) begin
                st_nxt.cfg.preamble_valid_level  = wd[7:4];
                st_nxt.cfg.preamble_detect_level = wd[3:1];
            end else if (st_r.wr_idx == rmb_pkg::IDX_CARRIER_CFG) begin
                st_nxt.cfg.carrier_level        = wd[7:5];
                st_nxt.cfg.preamble_count_level = wd[4:2];
            end else if (st_r.wr_idx == rmb_pkg::IDX_RSSI_CTRL) begin
                st_nxt.cfg.rssi_per_packet =
                    wd[rmb_pkg::RSSI_PACKET_BIT];
                st_nxt.pulse.rssi_go = wd[rmb_pkg::RSSI_ONESHOT_BIT]
                    & ~rssi_busy;
            end
        end

        st_nxt.wr_pend = addr_phase & hwrite_i;
        st_nxt.wr_idx  = addr_idx;
        if (addr_phase && !hwrite_i) begin
            st_nxt.rdata = rd_word;
        end

        // Power sequence
        case (st_r.pwr)
            PWR_AWAKE: begin
                if (st_r.pulse.sleep_req) begin
                    st_nxt.pwr       = PWR_SLEEP;
                    st_nxt.osc_ready = 1'b0;
                end
            end
            PWR_SLEEP: begin
                if (st_r.wake_sync[2]) begin
                    st_nxt.pwr        = PWR_WARMUP;
                    st_nxt.wake_count = 9'h000;
                end
            end
            PWR_WARMUP: begin
                // Count sleep ticks up to the start-up count
                if (st_r.wake_count >= st_r.cfg.osc_startup_count) begin
                    st_nxt.pwr       = PWR_AWAKE;
                    st_nxt.osc_ready = 1'b1;
                end else if (tick_rise) begin
                    st_nxt.wake_count = st_r.wake_count + 9'h001;
                end
            end
            default: begin
                st_nxt.pwr = PWR_AWAKE;
            end
        endcase
    end

    // ========================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.cfg.osc_startup_count     <= rmb_pkg::OSC_COUNT_RST;
            st_r.cfg.slot2_suite_sel       <= rmb_pkg::SUITE_RST;
            st_r.cfg.slot1_suite_sel       <= rmb_pkg::SUITE_RST;
            st_r.cfg.channel_check_mode    <= rmb_pkg::CCA_MODE_RST;
            st_r.cfg.channel_check_cs_level <= rmb_pkg::CCA_CS_RST;
            st_r.cfg.preamble_valid_level  <= rmb_pkg::PRE_VALID_RST;
            st_r.cfg.preamble_detect_level <= rmb_pkg::PRE_DETECT_RST;
            st_r.cfg.carrier_level         <= rmb_pkg::CARRIER_RST;
            st_r.cfg.preamble_count_level  <= rmb_pkg::PRE_COUNT_RST;
            st_r.pwr                       <= PWR_AWAKE;
            st_r.osc_ready                 <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // Outputs
    assign hrdata_o         = st_r.rdata;
    assign hreadyout_o      = 1'b1;
    assign hresp_o          = 1'b0;
    assign cfg_o            = st_r.cfg;
    assign pulse_o          = st_r.pulse;
    assign asleep_o         = (st_r.pwr != PWR_AWAKE);
    assign osc_ready_o      = st_r.osc_ready;
    // Level follows the reset bit
    assign radio_fsm_hold_o = st_r.cfg.radio_fsm_reset;
    assign cipher_busy_o    = cipher_busy;
    assign rssi_done_o      = ~(rssi_busy | st_r.pulse.rssi_go);
    // Source select only decodes the two legal codes
    assign tick_internal_o  = (sleep_tick_source_i
        == rmb_pkg::TICK_INTERNAL);
    assign tick_crystal_o   = (sleep_tick_source_i
        == rmb_pkg::TICK_CRYSTAL);

endmodule

`default_nettype wire

// ---- rtl/rmb_pkg.sv ----
// Package for the radio mode and baseband register bank
package rmb_pkg;

    // ========================================
    // Register offsets (byte address = 4 x index)
    localparam logic [7:0] IDX_SLEEP_WAKE   = 8'h35;
    localparam logic [7:0] IDX_MODE_CTRL    = 8'h36;
    localparam logic [7:0] IDX_SEC_SUITE    = 8'h37;
    localparam logic [7:0] IDX_RATE_SEL     = 8'h38;
    localparam logic [7:0] IDX_DEC_INVERT   = 8'h39;
    localparam logic [7:0] IDX_CHAN_CHECK   = 8'h3A;
    localparam logic [7:0] IDX_PREAMBLE_CFG = 8'h3B;
    localparam logic [7:0] IDX_CARRIER_CFG  = 8'h3C;
    localparam logic [7:0] IDX_RSSI_CTRL    = 8'h3E;

    // ========================================
    // Field positions
    localparam int SLEEP_REQ_BIT     = 7;
    localparam int MODE_RESET_BIT    = 2;
    localparam int MODE_TX_BIT       = 1;
    localparam int MODE_RX_BIT       = 0;
    localparam int DECRYPT_BIT       = 7;
    localparam int ENCRYPT_BIT       = 6;
    localparam int RATE_BIT          = 0;
    localparam int INVERT_BIT        = 2;
    localparam int RSSI_ONESHOT_BIT  = 7;
    localparam int RSSI_PACKET_BIT   = 6;
    localparam int RSSI_DONE_BIT     = 0;

    // ========================================
    // Reset values and recommended settings
    localparam logic [8:0] OSC_COUNT_RST   = 9'h000;
    localparam logic [8:0] OSC_COUNT_REC   = 9'h05F;
    localparam logic [2:0] SUITE_RST       = 3'h0;
    localparam logic [1:0] CCA_MODE_RST    = 2'h1;
    localparam logic [3:0] CCA_CS_RST      = 4'h2;
    localparam logic [3:0] CCA_CS_REC      = 4'hE;
    localparam logic [3:0] PRE_VALID_RST   = 4'hD;
    localparam logic [3:0] PRE_VALID_FAST  = 4'h3;
    localparam logic [2:0] PRE_DETECT_RST  = 3'h4;
    localparam logic [2:0] CARRIER_RST     = 3'h4;
    localparam logic [2:0] CARRIER_FAST    = 3'h2;
    localparam logic [2:0] PRE_COUNT_RST   = 3'h7;
    localparam logic [1:0] SLEEP_SRC_RST   = 2'h2;

    // ========================================
    // Timing
    localparam int CLK_HZ            = 50_000_000;
    localparam int RF_CAL_US         = 192;
    localparam int RF_CAL_CYCLES     = (RF_CAL_US * (CLK_HZ / 1_000_000));
    localparam int RSSI_CYCLES       = 16;
    localparam int CIPHER_CYCLES     = 32;

    // ========================================
    // Encodings
    typedef enum logic [2:0] {
        SUITE_NONE     = 3'h0,
        SUITE_CTR      = 3'h1,
        SUITE_CCM_128  = 3'h2,
        SUITE_CCM_64   = 3'h3,
        SUITE_CCM_32   = 3'h4,
        SUITE_MAC_128  = 3'h5,
        SUITE_MAC_64   = 3'h6,
        SUITE_MAC_32   = 3'h7
    } rmb_suite_e;

    typedef enum logic [1:0] {
        CCA_RESERVED   = 2'h0,
        CCA_CARRIER    = 2'h1,
        CCA_ENERGY     = 2'h2,
        CCA_BOTH       = 2'h3
    } rmb_cca_e;

    typedef enum logic [1:0] {
        TICK_INTERNAL  = 2'h2,
        TICK_CRYSTAL   = 2'h1
    } rmb_tick_e;

    // ========================================
    // Carriers
    typedef struct packed {
        logic [8:0] osc_startup_count;
        logic       radio_fsm_reset;
        logic       force_tx_state;
        logic       force_rx_state;
        logic [2:0] slot2_suite_sel;
        logic [2:0] slot1_suite_sel;
        logic       high_rate;
        logic       rx_symbol_invert;
        logic [1:0] channel_check_mode;
        logic [3:0] channel_check_cs_level;
        logic [3:0] preamble_valid_level;
        logic [2:0] preamble_detect_level;
        logic [2:0] carrier_level;
        logic [2:0] preamble_count_level;
        logic       rssi_per_packet;
    } rmb_cfg_s;

    typedef struct packed {
        logic       sleep_req;
        logic       decrypt_go;
        logic       encrypt_go;
        logic       rssi_go;
    } rmb_pulse_s;

endpackage

// ---- rtl/rmb_op_timer.sv ----
// One-shot busy timer for a self-clearing operation trigger
`timescale 1ns/100ps
`default_nettype none

module rmb_op_timer #(
    parameter int CYCLES = 16
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    typedef struct packed {
        logic [15:0] count;
        logic        busy;
        logic        done;
    } rmb_tmr_s;

    localparam logic [15:0] LAST = 16'(CYCLES - 1);

    rmb_tmr_s st_r;
    rmb_tmr_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (st_r.busy) begin
            if (st_r.count == LAST) begin
                st_nxt.busy  = 1'b0;
                st_nxt.done  = 1'b1;
                st_nxt.count = 16'h0000;
            end else begin
                st_nxt.count = st_r.count + 16'h0001;
            end
        end else if (start_i) begin
            st_nxt.busy  = 1'b1;
            st_nxt.count = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
    assign done_o = st_r.done;

endmodule

`default_nettype wire

// ---- dv/rmb_regs_monitor.sv ----
// Port-level checker for the radio mode and baseband register bank
`timescale 1ns/100ps
`default_nettype none

module rmb_regs_monitor (
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic                hreadyout_o,
    input wire logic                hresp_o,
    input wire logic [1:0]          sleep_tick_source_i,
    input wire logic                asleep_o,
    input wire logic                osc_ready_o,
    input wire rmb_pkg::rmb_cfg_s   cfg_o,
    input wire rmb_pkg::rmb_pulse_s pulse_o,
    input wire logic                radio_fsm_hold_o,
    input wire logic                cipher_busy_o,
    input wire logic                rssi_done_o,
    input wire logic                tick_internal_o,
    input wire logic                tick_crystal_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ========================================
    // Properties
    property p_bus_okay;
        hreadyout_o && !hresp_o;
    endproperty
    property p_hold;
        radio_fsm_hold_o == cfg_o.radio_fsm_reset;
    endproperty
    property p_source;
        tick_internal_o == (sleep_tick_source_i == 2'h2)
            && tick_crystal_o == (sleep_tick_source_i == 2'h1);
    endproperty
    property p_sleep;
        pulse_o.sleep_req |=> asleep_o && !osc_ready_o && !pulse_o.sleep_req;
    endproperty
    property p_warm;
        $rose(asleep_o) |-> !osc_ready_o;
    endproperty
    property p_rssi;
        pulse_o.rssi_go |=> !rssi_done_o [*8];
    endproperty
    property p_cipher;
        (pulse_o.encrypt_go || pulse_o.decrypt_go) |=> cipher_busy_o [*8];
    endproperty
    property p_dec_wins;
        pulse_o.decrypt_go |-> !pulse_o.encrypt_go;
    endproperty
    // Reset is the cause, so never disabled
    property p_rst;
        disable iff (1'b0)
        !reset_n_i |=> cfg_o.channel_check_mode == 2'h1
            && cfg_o.channel_check_cs_level == 4'h2
            && cfg_o.preamble_valid_level == 4'hD
            && cfg_o.preamble_detect_level == 3'h4
            && cfg_o.carrier_level == 3'h4
            && cfg_o.preamble_count_level == 3'h7
            && cfg_o.osc_startup_count == 9'h000
            && cfg_o.slot2_suite_sel == 3'h0
            && cfg_o.slot1_suite_sel == 3'h0 && !cfg_o.high_rate;
    endproperty

    a_bus_okay: assert property (p_bus_okay)
        else $error("bus not ready or not okay");
    a_hold: assert property (p_hold)
        else $error("hold differs from reset bit");
    a_source: assert property (p_source)
        else $error("tick source decode wrong");
    a_sleep: assert property (p_sleep)
        else $error("sleep not entered");
    a_warm: assert property (p_warm)
        else $error("oscillator ready in sleep");
    a_rssi: assert property (p_rssi)
        else $error("rssi done while measuring");
    a_cipher: assert property (p_cipher)
        else $error("cipher busy not held");
    a_dec_wins: assert property (p_dec_wins)
        else $error("both cipher triggers pulsed");
    a_rst: assert property (p_rst)
        else $error("reset value wrong");

    c_sleep: cover property (pulse_o.sleep_req);
    c_rssi: cover property (pulse_o.rssi_go);
    c_cipher: cover property (pulse_o.decrypt_go);
endmodule

bind rmb_regs rmb_regs_monitor u_mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .sleep_tick_source_i(sleep_tick_source_i),
    .asleep_o(asleep_o), .osc_ready_o(osc_ready_o), .cfg_o(cfg_o),
    .pulse_o(pulse_o), .radio_fsm_hold_o(radio_fsm_hold_o),
    .cipher_busy_o(cipher_busy_o), .rssi_done_o(rssi_done_o),
    .tick_internal_o(tick_internal_o), .tick_crystal_o(tick_crystal_o)
);

`default_nettype wire

// ---- dv/rmb_host.sv ----
// Host software model: single-word AHB-Lite master
`timescale 1ns/100ps
`default_nettype none

module rmb_host (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [9:0]       haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial begin
        hsel_o = 1'b1;
        haddr_o = 10'h000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h00000000;
    end

    // Callers pass only defined fields, reserved bits zero, except one all-ones write to unmapped index 3D
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        haddr_o <= {idx, 2'h0};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= {24'h000000, wd};
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_i[7:0];
    endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench for the register bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic                clk_i = 1'b0;
    logic                reset_n_i = 1'b0;
    logic                sleep_tick_i = 1'b0;
    logic                wake_i = 1'b0;
    logic [1:0]          src = 2'h2;
    wire logic           hsel, hwrite, hready, hresp;
    wire logic [9:0]     haddr;
    wire logic [1:0]     htrans;
    wire logic [2:0]     hsize;
    wire logic [31:0]    hwdata, hrdata;
    wire logic           asleep_o, osc_ready_o, hold, busy, rssi_done;
    wire logic           t_int, t_xtal;
    rmb_pkg::rmb_cfg_s   cfg;
    int                  fail_count = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    always #10 clk_i = ~clk_i;

    rmb_host host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    rmb_regs uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .sleep_tick_i(sleep_tick_i), .wake_i(wake_i),
        .sleep_tick_source_i(src), .asleep_o(asleep_o),
        .osc_ready_o(osc_ready_o), .cfg_o(cfg), .pulse_o(),
        .radio_fsm_hold_o(hold), .cipher_busy_o(busy),
        .rssi_done_o(rssi_done), .tick_internal_o(t_int),
        .tick_crystal_o(t_xtal));

    // ========================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] v;
        host.xfer(1'b1, idx, d, v);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        host.xfer(1'b0, idx, 8'h00, v);
        chk(v, exp);
    endtask

    task automatic wr_rd(input logic [7:0] idx, input logic [7:0] d);
        wr(idx, d);
        rd_chk(idx, d);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end
        else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset;
        logic [15:0] ie [10] = '{16'h3500, 16'h3600, 16'h3700, 16'h3800,
            16'h3900, 16'h3A48, 16'h3BD8, 16'h3C9C, 16'h3E01, 16'h3D00};
        for (int i = 0; i < 10; i++) begin
            rd_chk(ie[i][15:8], ie[i][7:0]);
        end
        $display("reset values test done");
    endtask

    task automatic t_fields;
        for (int m = 0; m < 4; m++) begin
            wr_rd(8'h3A, {m[1:0], 4'hE, 2'h0});
            chk(cfg.channel_check_mode, m[1:0]);
        end
        for (int s = 0; s < 8; s++) begin
            wr_rd(8'h37, {2'h0, s[2:0], ~s[2:0]});
            chk({cfg.slot2_suite_sel, cfg.slot1_suite_sel},
                {s[2:0], ~s[2:0]});
        end
        wr_rd(8'h38, 8'h01);
        wr_rd(8'h39, 8'h04);
        chk({cfg.high_rate, cfg.rx_symbol_invert}, 2'h3);
        wr_rd(8'h3B, 8'h38);
        wr_rd(8'h3C, 8'h40);
        chk({cfg.preamble_valid_level, cfg.carrier_level}, 7'h1A);
        wr(8'h3D, 8'hFF);
        rd_chk(8'h3D, 8'h00);
        $display("field test done");
    endtask

    task automatic t_sleep;
        int ticks = 0;
        wr(8'h36, 8'h10);
        wr(8'h35, 8'h5F);
        rd_chk(8'h36, 8'h10);
        chk(cfg.osc_startup_count, 9'h15F);
        wr(8'h36, 8'h00);
        wr(8'h35, 8'h83);
        repeat (3) @(posedge clk_i);
        chk({asleep_o, osc_ready_o}, 2'h2);
        rd_chk(8'h35, 8'h03);
        wake_i <= 1'b1;
        for (int n = 0; n < 400 && osc_ready_o !== 1'b1; n++) begin
            @(posedge clk_i);
            if (n % 4 == 0) begin
                if (!sleep_tick_i) ticks++;
                sleep_tick_i <= ~sleep_tick_i;
            end
        end
        chk(osc_ready_o, 1'b1);
        chk(ticks >= 3, 1'b1);
        wake_i <= 1'b0;
        sleep_tick_i <= 1'b0;
        for (int v = 0; v < 4; v++) begin
            src <= v[1:0];
            repeat (2) @(posedge clk_i);
            chk({t_int, t_xtal}, {v == 2, v == 1});
        end
        $display("sleep test done");
    endtask

    task automatic t_mode;
        wr_rd(8'h36, 8'h06);
        chk({hold, cfg.force_tx_state}, 2'h3);
        wr_rd(8'h36, 8'h02);
        chk({hold, cfg.force_tx_state}, 2'h1);
        repeat (rmb_pkg::RF_CAL_CYCLES) @(posedge clk_i);
        wr_rd(8'h36, 8'h01);
        chk({cfg.force_tx_state, cfg.force_rx_state}, 2'h1);
        $display("mode test done");
    endtask

    task automatic t_trigger;
        logic [15:0] gr [3] = '{16'h4040, 16'h8080, 16'hC080};
        for (int i = 0; i < 3; i++) begin
            wr(8'h37, gr[i][15:8]);
            rd_chk(8'h37, gr[i][7:0]);
            chk(busy, 1'b1);
            for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk_i);
            rd_chk(8'h37, 8'h00);
        end
        wr(8'h3E, 8'h80);
        rd_chk(8'h3E, 8'h00);
        chk(rssi_done, 1'b0);
        for (int n = 0; n < 100 && rssi_done !== 1'b1; n++) @(posedge clk_i);
        rd_chk(8'h3E, 8'h01);
        wr(8'h3E, 8'h40);
        rd_chk(8'h3E, 8'h41);
        chk(cfg.rssi_per_packet, 1'b1);
        $display("trigger test done");
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_fields();
        t_sleep();
        t_mode();
        t_trigger();
        report_and_stop();
    end
endmodule

`default_nettype wire
